// *** include/sfw_map.svh ***
// Constants for the serial flash wrap, enhance and erase sequencer
`ifndef SFW_MAP_SVH
`define SFW_MAP_SVH
`define SFW_OP_WRITE_ENABLE_CMD 8'h06
`define SFW_OP_BURST 8'hC0
`define SFW_OP_SECT 8'h20
`define SFW_OP_HALF 8'h52
`define SFW_OP_BLK 8'hD8
`define SFW_OP_QREAD 8'hEB
`define SFW_OP_FREAD 8'h0B
`define SFW_OP_WREAD 8'hE7
`define SFW_MODE_EXIT 8'hFF
`define SFW_WRAP_OFF 8'h10
`define SFW_ERASE_CYC 16'h0100
`define SFW_DIV_HALF 8'h0A
`define SFW_APB_CTRL 12'h000
`define SFW_APB_ADDR 12'h004
`define SFW_APB_STAT 12'h008
`define SFW_APB_DATA 12'h00C
`define SFW_CTRL_GO 0
`define SFW_CTRL_QUAD 1
`define SFW_CTRL_NBYTE 4
`endif

// *** include/sfw_pkg.sv ***
// Types for the serial flash sequencer
package sfw_pkg;
  typedef enum logic [2:0] {
    SFW_IDLE = 3'b000, SFW_CMD = 3'b001, SFW_ADDR = 3'b011, SFW_MODE = 3'b010,
    SFW_DATA = 3'b110, SFW_SKIP = 3'b111
  } sfw_phase_t;
  typedef enum logic [1:0] {
    SFW_H_IDLE = 2'b00, SFW_H_RUN = 2'b01, SFW_H_LOW = 2'b11, SFW_H_DONE = 2'b10
  } sfw_hstate_t;
endpackage

// *** include/sfw_if.sv ***
// Serial flash link between host controller and flash device
`timescale 1ns/1ps
interface sfw_if;
  logic cs_n;
  logic sclk;
  logic [3:0] io_host;
  logic [3:0] io_host_oe;
  logic [3:0] io_dev;
  logic [3:0] io_dev_oe;
  modport host (output cs_n, output sclk, output io_host, output io_host_oe, input io_dev, input io_dev_oe);
  modport dev (input cs_n, input sclk, input io_host, input io_host_oe, output io_dev, output io_dev_oe);
endinterface

// *** src/sfw_sync.sv ***
// Two-flop synchroniser for link inputs
`timescale 1ns/1ps
module sfw_sync #(
  parameter int W = 1
) (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  // A zero-width bus cannot be synchronised
  if (W < 1) begin
    $error("W must be at least 1");
  end
  logic [W-1:0] meta; // First stage, read only by o_q
  // Both stages in one clocked process
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      meta <= '0;
      o_q <= '0;
    end else begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule

// *** src/sfw_dev.sv ***
// Flash device end: wrap config, enhance mode and erase sequencing
// Functional notes
// - Wrapping off after reset
// - Wrap inside aligned window of size
// - Host sends opcode, wrap code, deselects
// - Codes 00h-03h select 8-64, 1xh off
// - Wrap persists; resend replaces depth
// - Code 1xh turns wrapping off
// - Wrap applies to listed quad reads
// - Burst opcode 8 or 2 clocks
// - Toggling mode byte enters enhance mode
// - Enhance only for listed reads
// - Enhance: next frame starts with address
// - Non-toggling or FFh mode exits enhance
// - Host resets with plain single-wire commands
// - Host sends write enable before erase
// - Sector erase needs exact 32-bit frame
// - Sector is address bits top..A12
// - Erase starts at deselect; busy flag
// - Protected sector not erased
// - Half block erase aligned 32K
// - Block erase aligned 64K, protect honoured
// - Erase opcodes 8 or 2 clocks
// - Host keeps enhance with complementary nibbles
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
`include "sfw_map.svh"
module sfw_dev import sfw_pkg::*; #(
  parameter int AW = 21,
  parameter logic [15:0] ERASE_CYC = `SFW_ERASE_CYC
) (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  sfw_if.dev link,
  input wire logic I_QUAD_CMD_MODE,
  input wire logic [3:0] I_PROTECT,
  output logic O_WRITE_ENABLE_LATCH,
  output logic O_WRITE_IN_PROGRESS,
  output logic O_WRAP_ON,
  output logic [6:0] O_WRAP_LEN,
  output logic O_ENHANCE,
  output logic O_ERASE_PULSE,
  output logic [AW-1:0] O_ERASE_BASE,
  output logic [AW-1:0] O_ERASE_SPAN,
  output logic [AW-1:0] O_READ_START,
  output logic [AW-1:0] O_READ_NEXT
);
  // Address width outside what the protect and span logic can serve
  if (AW < 16 || AW > 24) begin
    $error("AW out of range");
  end
  // Protected region: top fraction selected by protect bits
  function automatic logic is_prot(input logic [3:0] bp, input logic [AW-1:0] a);
    logic [4:0] sh;
    sh = 5'(AW) - 5'(bp);
    is_prot = (bp != 4'h0) && ((a >> sh) != '0 || 5'(bp) >= 5'(AW));
  endfunction
  // Window wrap of the running read address
  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] a, input logic [6:0] len, input logic on);
    logic [AW-1:0] m;
    m = AW'(len) - 1'b1;
    wrap_inc = on ? ((a & ~m) | ((a + 1'b1) & m)) : a + 1'b1;
  endfunction
  typedef struct packed {
    logic [2:0] cs_d; // Deselect edge history
    logic sclk_d; // Previous synced clock
    sfw_phase_t ph;
    logic [5:0] bits; // Bits taken in current phase
    logic [7:0] op;
    logic [23:0] addr;
    logic [7:0] mode;
    logic write_enable_latch;
    logic write_in_progress;
    logic [15:0] cnt;
    logic wrap_on;
    logic [6:0] wrap_len;
    logic enh;
    logic [7:0] enh_op;
    logic erase;
    logic [AW-1:0] ebase;
    logic [AW-1:0] espan;
    logic [AW-1:0] rptr;
    logic [AW-1:0] rstart;
  } sfw_dstate_t;
  sfw_dstate_t r, next_r;
  logic [5:0] s_in; // cs, sclk, io[3:0] after sync
  sfw_sync #(.W(6)) u_sync (
    .I_CLK(I_CLK),
    .I_RST_N(I_RST_N),
    .i_d({link.cs_n, link.sclk, link.io_host}),
    .o_q(s_in)
  );
  logic cs_n_s, rise, cs_rise, quad;
  logic [3:0] io_s;
  logic [2:0] step;
  logic [AW-1:0] ea;
  assign cs_n_s = s_in[5];
  assign io_s = s_in[3:0];
  assign rise = s_in[4] & ~r.sclk_d & ~cs_n_s;
  assign cs_rise = cs_n_s & ~r.cs_d[0];
  assign quad = I_QUAD_CMD_MODE;
  assign step = quad ? 3'd4 : 3'd1;
  assign ea = r.addr[AW-1:0];
  // Next-state logic for the command decoder and erase timer
  always_comb begin
    next_r = r;
    next_r.cs_d = {r.cs_d[1:0], cs_n_s};
    next_r.sclk_d = s_in[4];
    next_r.erase = 1'b0;
    if (r.write_in_progress) begin
      // Erase timer; busy ends with latch clear
      if (r.cnt == 16'h0001) begin
        next_r.write_in_progress = 1'b0;
        next_r.write_enable_latch = 1'b0;
      end
      next_r.cnt = r.cnt - 16'h0001;
    end
    if (cs_rise) begin
      // Frame end: decide on the full command
      // A finished opcode other than burst leaves the decoder in address phase with no bits taken
      if (r.ph == SFW_ADDR && r.bits == 6'd0 && r.op == `SFW_OP_WRITE_ENABLE_CMD && !r.write_in_progress) next_r.write_enable_latch = 1'b1;
      if (r.ph == SFW_DATA && r.op == `SFW_OP_BURST && r.bits == 6'd8) begin
        if (r.mode[7:4] == 4'h1) next_r.wrap_on = 1'b0;
        else if (r.mode[7:2] == 6'h00) begin
          next_r.wrap_on = 1'b1;
          next_r.wrap_len = 7'd8 << r.mode[1:0];
        end
      end
      // Erase only on exact address end, latch set, idle
      if (r.ph == SFW_ADDR && r.bits == 6'd24 && r.write_enable_latch && !r.write_in_progress &&
          (r.op == `SFW_OP_SECT || r.op == `SFW_OP_HALF || r.op == `SFW_OP_BLK)) begin
        if (r.op == `SFW_OP_SECT) next_r.espan = AW'(32'h1000);
        else if (r.op == `SFW_OP_HALF) next_r.espan = AW'(32'h8000);
        else next_r.espan = AW'(32'h10000);
        next_r.ebase = ea & ~(next_r.espan - 1'b1);
        next_r.write_in_progress = 1'b1;
        next_r.cnt = ERASE_CYC;
        next_r.erase = !is_prot(I_PROTECT, ea);
        if (is_prot(I_PROTECT, ea)) begin
          next_r.write_in_progress = 1'b0;
          next_r.write_enable_latch = 1'b0;
        end
      end
      next_r.ph = SFW_IDLE;
    end else if (cs_n_s) begin
      next_r.ph = SFW_IDLE;
    end else if (r.ph == SFW_IDLE) begin
      // Frame start: enhance skips the opcode
      next_r.ph = r.enh ? SFW_ADDR : SFW_CMD;
      next_r.op = r.enh ? r.enh_op : 8'h00;
      next_r.bits = 6'd0;
    end else if (rise) begin
      case (r.ph)
        SFW_CMD: begin
          // Single wire samples line 0 only
          next_r.op = quad ? {r.op[3:0], io_s} : {r.op[6:0], io_s[0]};
          next_r.bits = r.bits + 6'(step);
          if (r.bits + 6'(step) == 6'd8) begin
            next_r.ph = SFW_ADDR;
            if (next_r.op == `SFW_OP_BURST) next_r.ph = SFW_DATA;
            next_r.bits = 6'd0;
          end
        end
        SFW_ADDR: begin
          // Quad reads shift four lines, erase per frame width
          if (quad || r.op == `SFW_OP_QREAD || r.op == `SFW_OP_WREAD) begin
            next_r.addr = {r.addr[19:0], io_s};
            next_r.bits = r.bits + 6'd4;
          end else begin
            next_r.addr = {r.addr[22:0], io_s[0]};
            next_r.bits = r.bits + 6'd1;
          end
          if (next_r.bits == 6'd24 && (r.op == `SFW_OP_QREAD || r.op == `SFW_OP_WREAD ||
              (quad && r.op == `SFW_OP_FREAD))) begin
            next_r.ph = SFW_MODE;
            next_r.bits = 6'd0;
          end
        end
        SFW_MODE: begin
          next_r.mode = {r.mode[3:0], io_s};
          next_r.bits = r.bits + 6'd4;
          if (r.bits == 6'd4) begin
            // Enter on toggle, leave on non-toggle or FFh
            next_r.enh = (next_r.mode[7:4] == ~next_r.mode[3:0]) && next_r.mode != `SFW_MODE_EXIT;
            next_r.enh_op = r.op;
            next_r.rstart = ea;
            next_r.rptr = ea;
            next_r.ph = SFW_DATA;
            next_r.bits = 6'd0;
          end
        end
        SFW_DATA: begin
          if (r.op == `SFW_OP_BURST) begin
            // Wrap code byte after burst opcode
            if (r.bits < 6'd8) begin
              next_r.mode = quad ? {r.mode[3:0], io_s} : {r.mode[6:0], io_s[0]};
              next_r.bits = r.bits + 6'(step);
            end else next_r.bits = 6'd9;
          end else begin
            // Count read nibbles; advance inside window
            next_r.bits = r.bits + 6'd4;
            if (r.bits[2:0] == 3'd4) next_r.rptr = wrap_inc(r.rptr, r.wrap_len, r.wrap_on);
          end
        end
        default: next_r.ph = SFW_SKIP;
      endcase
    end
  end
  // State register; wrap disabled at reset
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      r <= '0;
      r.cs_d <= 3'b111;
      r.wrap_len <= 7'd8;
    end else begin
      r <= next_r;
    end
  end
  assign link.io_dev = 4'h0; // Read data path lies outside this block
  assign link.io_dev_oe = 4'h0;
  assign O_WRITE_ENABLE_LATCH = r.write_enable_latch;
  assign O_WRITE_IN_PROGRESS = r.write_in_progress;
  assign O_WRAP_ON = r.wrap_on;
  assign O_WRAP_LEN = r.wrap_len;
  assign O_ENHANCE = r.enh;
  assign O_ERASE_PULSE = r.erase;
  assign O_ERASE_BASE = r.ebase;
  assign O_ERASE_SPAN = r.espan;
  assign O_READ_START = r.rstart;
  assign O_READ_NEXT = r.rptr;
endmodule

// *** src/sfw_host.sv ***
// Host controller end: APB-programmed frame sender
// host issues single-wire or quad frames per the control quad bit; software sends write enable before erase
// mode byte written by software; complementary nibbles keep enhance mode
`timescale 1ns/1ps
`include "sfw_map.svh"
module sfw_host import sfw_pkg::*; #(
  parameter logic [7:0] DIV_HALF = `SFW_DIV_HALF
) (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  sfw_if.host link,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR
);
  // A zero half period would wrap the divider and toggle the link clock only every 256 cycles
  if (DIV_HALF == 8'h00) begin
    $error("DIV_HALF must be nonzero");
  end
  typedef struct packed {
    sfw_hstate_t st;
    logic [7:0] div;
    logic rdy; // Ready, raised in the second access cycle
    logic quad;
    logic [63:0] sh; // Opcode, address, extra bytes, MSB first
    logic [31:0] ctrl;
    logic [31:0] addr;
    logic [31:0] data;
    logic [31:0] prdata;
    logic sclk;
    logic cs_n;
    logic [3:0] io;
    logic [5:0] left;
  } sfw_hreg_t;
  sfw_hreg_t r, next_r;
  logic acc;
  assign acc = I_PSEL & I_PENABLE;
  // Sequencer and register writes
  always_comb begin
    next_r = r;
    // One wait state: read data is loaded on the same edge that raises ready
    next_r.rdy = acc && !r.rdy;
    if (acc && r.rdy && I_PWRITE && r.st == SFW_H_IDLE) begin
      if (I_PADDR == `SFW_APB_CTRL) next_r.ctrl = I_PWDATA;
      else if (I_PADDR == `SFW_APB_ADDR) next_r.addr = I_PWDATA;
      else if (I_PADDR == `SFW_APB_DATA) next_r.data = I_PWDATA;
    end
    if (acc && !r.rdy && !I_PWRITE) begin
      if (I_PADDR == `SFW_APB_CTRL) next_r.prdata = r.ctrl;
      else if (I_PADDR == `SFW_APB_ADDR) next_r.prdata = r.addr;
      else if (I_PADDR == `SFW_APB_STAT) next_r.prdata = {31'h0, r.st != SFW_H_IDLE};
      else if (I_PADDR == `SFW_APB_DATA) next_r.prdata = r.data;
      else next_r.prdata = 32'h0;
    end
    case (r.st)
      SFW_H_IDLE: begin
        if (next_r.ctrl[`SFW_CTRL_GO]) begin
          next_r.ctrl[`SFW_CTRL_GO] = 1'b0;
          next_r.quad = next_r.ctrl[`SFW_CTRL_QUAD];
          next_r.sh = {next_r.ctrl[15:8], next_r.addr[23:0], next_r.data};
          next_r.left = 6'(next_r.ctrl[21:16]); // Bits to send
          next_r.cs_n = 1'b0;
          next_r.div = 8'h00;
          next_r.st = SFW_H_RUN;
          next_r.io = next_r.quad ? next_r.sh[63:60] : {3'b000, next_r.sh[63]};
        end
      end
      SFW_H_RUN: begin
        // Divider enables the link clock toggle
        next_r.div = r.div + 8'h01;
        if (r.div == DIV_HALF - 8'h01) begin
          next_r.div = 8'h00;
          next_r.sclk = ~r.sclk;
          if (r.sclk) begin
            // Falling edge: shift next bits out
            next_r.sh = r.quad ? {r.sh[59:0], 4'h0} : {r.sh[62:0], 1'b0};
            next_r.io = r.quad ? next_r.sh[63:60] : {3'b000, next_r.sh[63]};
            if (r.left <= (r.quad ? 6'd4 : 6'd1)) next_r.st = SFW_H_LOW;
            else next_r.left = r.left - (r.quad ? 6'd4 : 6'd1);
          end
        end
      end
      SFW_H_LOW: begin
        // Hold after last falling edge, then deselect
        next_r.div = r.div + 8'h01;
        if (r.div == DIV_HALF - 8'h01) begin
          next_r.cs_n = 1'b1;
          next_r.div = 8'h00;
          next_r.st = SFW_H_DONE;
        end
      end
      default: begin
        next_r.div = r.div + 8'h01;
        if (r.div == DIV_HALF - 8'h01) next_r.st = SFW_H_IDLE;
      end
    endcase
  end
  // State register
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      r <= '0;
      r.cs_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end
  assign link.cs_n = r.cs_n;
  assign link.sclk = r.sclk;
  assign link.io_host = r.io;
  assign link.io_host_oe = r.cs_n ? 4'h0 : (r.quad ? 4'hF : 4'h1);
  assign O_PRDATA = r.prdata;
  assign O_PREADY = r.rdy;
  assign O_PSLVERR = 1'b0;
endmodule

// *** verification/sfw_assertions.sv ***
// Assertion checker for the flash link and device status
`timescale 1ns/1ps
module sfw_assertions #(
  parameter int AW = 21,
  parameter logic [15:0] ERASE_CYC = 16'h0100
) (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic cs_n,
  input wire logic O_WRITE_ENABLE_LATCH,
  input wire logic O_WRITE_IN_PROGRESS,
  input wire logic O_WRAP_ON,
  input wire logic [6:0] O_WRAP_LEN,
  input wire logic O_ENHANCE,
  input wire logic O_ERASE_PULSE,
  input wire logic [AW-1:0] O_ERASE_BASE,
  input wire logic [AW-1:0] O_ERASE_SPAN,
  input wire logic [AW-1:0] O_READ_START,
  input wire logic [AW-1:0] O_READ_NEXT
);
  default clocking dc @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);
  // Cycles spent busy; a wrong erase time shows up here
  logic [15:0] busy_cnt;
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      busy_cnt <= 16'h0000;
    end else begin
      busy_cnt <= O_WRITE_IN_PROGRESS ? busy_cnt + 16'h0001 : 16'h0000;
    end
  end
  wrap_reset_off_a: assert property ($rose(I_RST_N) |-> !O_WRAP_ON)
    else $error("wrap on after reset");
  wrap_len_code_a: assert property (O_WRAP_ON |-> O_WRAP_LEN inside {7'h08, 7'h10, 7'h20, 7'h40})
    else $error("illegal wrap length");
  // Only a moving read pointer is judged, so stale linear reads do not count
  wrap_window_a: assert property (O_WRAP_ON && $changed(O_READ_NEXT) |->
    ((O_READ_NEXT ^ O_READ_START) & ~AW'(O_WRAP_LEN - 7'h01)) == '0)
    else $error("read left wrap window");
  erase_busy_a: assert property (O_ERASE_PULSE |-> ##[0:2] O_WRITE_IN_PROGRESS)
    else $error("erase without busy flag");
  erase_deselect_a: assert property (O_ERASE_PULSE |-> cs_n && $past(cs_n))
    else $error("erase before deselect");
  erase_needs_wel_a: assert property (O_ERASE_PULSE |-> $past(O_WRITE_ENABLE_LATCH))
    else $error("erase without write enable");
  erase_span_a: assert property (O_ERASE_PULSE |->
    32'(O_ERASE_SPAN) inside {32'h00001000, 32'h00008000, 32'h00010000} &&
    (O_ERASE_BASE & (O_ERASE_SPAN - 1'b1)) == '0)
    else $error("bad erase region");
  busy_ends_a: assert property ($fell(O_WRITE_IN_PROGRESS) |-> !O_WRITE_ENABLE_LATCH)
    else $error("latch kept after erase");
  busy_length_a: assert property ($fell(O_WRITE_IN_PROGRESS) |->
    busy_cnt + 16'h0002 >= ERASE_CYC && busy_cnt <= ERASE_CYC + 16'h0002)
    else $error("erase time wrong");
  cover property (O_ERASE_PULSE);
  cover property ($rose(O_WRAP_ON));
  cover property ($rose(O_ENHANCE));
endmodule

// *** verification/testbench.sv ***
// Self-checking bench joining the host and device ends
`timescale 1ns/1ps
`include "sfw_map.svh"
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, quad = 1'b0;
  logic [11:0] padr = 12'h000;
  logic [31:0] pwd = 32'h0, prd, r;
  logic prdy, perr, write_enable_latch, write_in_progress, won, enh, epl;
  logic [3:0] prot = 4'h0;
  logic [6:0] wlen;
  logic [20:0] ebase, espan, rs, rn, cb, cs;
  int bad_count = 0, checks = 0, pulses = 0;
  sfw_if lnk();
  always #4 clk = ~clk;
  sfw_host u_sfw_host (.I_CLK(clk), .I_RST_N(rst_n), .link(lnk), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(padr), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(prdy), .O_PSLVERR(perr));
  // Short erase time keeps the run brief
  sfw_dev #(.ERASE_CYC(16'h0010)) u_sfw_dev (.I_CLK(clk), .I_RST_N(rst_n), .link(lnk),
    .I_QUAD_CMD_MODE(quad), .I_PROTECT(prot), .O_WRITE_ENABLE_LATCH(write_enable_latch), .O_WRITE_IN_PROGRESS(write_in_progress),
    .O_WRAP_ON(won), .O_WRAP_LEN(wlen), .O_ENHANCE(enh), .O_ERASE_PULSE(epl), .O_ERASE_BASE(ebase),
    .O_ERASE_SPAN(espan), .O_READ_START(rs), .O_READ_NEXT(rn));
  sfw_assertions #(.ERASE_CYC(16'h0010)) u_sfw_assertions (.I_CLK(clk), .I_RST_N(rst_n), .cs_n(lnk.cs_n),
    .O_WRITE_ENABLE_LATCH(write_enable_latch), .O_WRITE_IN_PROGRESS(write_in_progress), .O_WRAP_ON(won), .O_WRAP_LEN(wlen),
    .O_ENHANCE(enh), .O_ERASE_PULSE(epl), .O_ERASE_BASE(ebase), .O_ERASE_SPAN(espan),
    .O_READ_START(rs), .O_READ_NEXT(rn));
  // Record every erase the device launches
  always @(posedge clk) begin
    if (epl) begin
      pulses <= pulses + 1;
      cb <= ebase;
      cs <= espan;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Expected read pointer after n bytes inside an aligned window of len bytes
  function automatic logic [20:0] wrap_exp(input logic [20:0] s, input int len, input int n);
    int off;
    off = int'(s) % len;
    wrap_exp = 21'(int'(s) - off + (off + n) % len);
  endfunction
  // One APB transfer; held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    r = prd;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // Read data stands when pready is seen high
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  // Send one frame and wait until the host is idle again
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input logic [31:0] d,
    input logic [5:0] n, input logic q);
    quad <= q;
    apb(1'b1, `SFW_APB_ADDR, {8'h00, a});
    apb(1'b1, `SFW_APB_DATA, d);
    apb(1'b1, `SFW_APB_CTRL, {10'h000, n, op, 6'h00, q, 1'b1});
    r = 32'h1;
    for (int i = 0; i < 300 && r[0] !== 1'b0; i++) rd(`SFW_APB_STAT);
    chk(r, 32'h0);
    // Device acts a few cycles after deselect
    repeat (8) @(posedge clk);
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Watchdog far beyond the expected run time
  initial begin
    #400000;
    bad_count++;
    conclude();
  end
  initial begin
    logic [23:0] a;
    logic [7:0] ops [3];
    logic [20:0] sp;
    logic [1:0] wc;
    void'($urandom(99));
    ops = '{`SFW_OP_SECT, `SFW_OP_HALF, `SFW_OP_BLK};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(won, 32'h0);
    rd(12'h010);
    chk(r, 32'h0);
    // Every wrap code, random command width for codes 00h-03h
    for (int c = 0; c < 4; c++) begin
      frame(`SFW_OP_BURST, {c[7:0], 16'h0000}, 32'h0, 6'h10, 1'($urandom));
      chk(won, 32'h1);
      chk(wlen, 32'h8 << c);
    end
    frame(`SFW_OP_BURST, {4'h1, 4'($urandom), 16'h0000}, 32'h0, 6'h10, 1'b0);
    chk(won, 32'h0);
    // Each erase kind at a random address
    foreach (ops[k]) begin
      a = 24'($urandom);
      sp = (k == 0) ? 21'h01000 : (k == 1) ? 21'h08000 : 21'h10000;
      frame(`SFW_OP_WRITE_ENABLE_CMD, 24'h0, 32'h0, 6'h08, 1'($urandom));
      chk(write_enable_latch, 32'h1);
      frame(ops[k], a, 32'h0, 6'h20, 1'($urandom));
      chk(pulses, k + 1);
      chk(cs, sp);
      chk(cb, a[20:0] & ~(sp - 21'h1));
      for (int i = 0; i < 200 && write_in_progress !== 1'b0; i++) @(posedge clk);
      chk(write_in_progress, 32'h0);
      chk(write_enable_latch, 32'h0);
    end
    frame(`SFW_OP_SECT, 24'($urandom), 32'h0, 6'h20, 1'b0);
    chk(write_in_progress, 32'h0);
    frame(`SFW_OP_WRITE_ENABLE_CMD, 24'h0, 32'h0, 6'h08, 1'b1);
    frame(`SFW_OP_SECT, 24'($urandom), 32'hA5000000, 6'h28, 1'b1);
    frame(`SFW_OP_HALF, 24'($urandom), 32'h0, 6'h18, 1'b0);
    prot <= 4'hF;
    frame(`SFW_OP_BLK, 24'hFFFFFF, 32'h0, 6'h20, 1'b0);
    chk(pulses, 3);
    prot <= 4'h0;
    // Random wrap depth, then an enhance read whose bytes cross the window end
    wc = 2'($urandom);
    frame(`SFW_OP_BURST, {6'h00, wc, 16'h0000}, 32'h0, 6'h10, 1'b0);
    chk(wlen, 32'h8 << wc);
    a = {18'($urandom), 6'h3E};
    frame(`SFW_OP_QREAD, a, 32'hA5000000, 6'h3C, 1'b1);
    chk(enh, 32'h1);
    chk(rs, a[20:0]);
    chk(rn, wrap_exp(a[20:0], 8 << wc, 2));
    a = 24'($urandom);
    frame(a[23:16], {a[15:0], 8'h5A}, 32'h0, 6'h20, 1'b1);
    chk(enh, 32'h1);
    chk(rs, a[20:0]);
    frame(a[23:16], {a[15:0], 8'hFF}, 32'h0, 6'h20, 1'b1);
    chk(enh, 32'h0);
    // Reset in mid-run drops the programmed wrap depth
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(won, 32'h0);
    chk(wlen, 32'h8);
    frame(`SFW_OP_FREAD, 24'($urandom), 32'h0, 6'h28, 1'b0);
    chk(enh, 32'h0);
    conclude();
  end
endmodule
